// [rtl/vmcr_regs.sv]
// Volatile mode configuration registers with their serial command front end
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////////////////////////
module vmcr_regs
  import vmcr_pkg::*;
(
  input  wire logic       mclk,                // Core clock
  input  wire logic       nrst,                // Reset, active low; synchronous on the core, asynchronous on the event word
  input  wire logic       sck,                 // Link clock, runs only in frames
  input  wire logic       cs_n,                // Link chip select, active low
  input  wire logic [3:0] link_din,            // Data lines in
  output logic      [3:0] link_dout,           // Data lines out
  output logic      [3:0] link_doe,            // Data line drive enables
  input  wire logic [7:0] config_one_live,     // Live config one, quad-enable inside
  input  wire logic [7:0] config_two_stored,   // Stored copy of config two
  input  wire logic [7:0] config_three_stored, // Stored copy of config three
  input  wire logic       sw_reset,            // Software reset pulse
  input  wire logic       stored_alen_upd,     // Stored boot length written, pulse
  input  wire logic       stored_alen_val,     // New stored boot length
  input  wire logic       reg_wr,              // Register write pulse from command logic
  input  wire logic       reg_wr_sel,          // 0 config two, 1 config three
  input  wire logic [7:0] reg_wr_data,         // Register write value
  input  wire logic       array_read,          // Current read targets main array
  output logic      [7:0] config_two_live,     // Live config two
  output logic      [7:0] config_three_live,   // Live config three
  output logic      [1:0] drive_strength_sel,  // Output impedance select
  output logic            protection_scheme_sel, // Protection method
  output logic            current_addr_len,    // 1 four bytes, 0 three
  output logic            quad_instruction_protocol, // Four-line instructions
  output vmcr_mode_t      mode,                // Line usage and read widths
  output logic            line_four_reset_req, // Hardware reset requested by pin
  output logic            burst_wrap_active    // Wrap applies to this read
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Link side: one frame per chip select, cleared by the frame's own select

  vmcr_frame_t f;
  vmcr_frame_t next_f;
  vmcr_event_t ev;
  vmcr_event_t next_ev;
  vmcr_core_t  r;
  vmcr_core_t  next_r;
  logic        lk_qpi;
  logic [3:0]  lk_last;
  logic [7:0]  lk_shifted;

  // Snapshots are only refreshed while select is high, so they are still here
  always_comb begin
    lk_qpi     = r.snap2[BIT_QPI];
    lk_last    = lk_qpi ? LAST_QUAD : LAST_SINGLE;
    lk_shifted = lk_qpi ? {f.sh_in[3:0], link_din} : {f.sh_in[6:0], link_din[0]};
  end

  // Frame sequencer and event raise
  always_comb begin
    next_f  = f;
    next_ev = ev;
    case (f.st)
      LK_CMD: begin
        next_f.sh_in = lk_shifted;
        next_f.cnt   = f.cnt + 4'h1;
        if (f.cnt == lk_last) begin
          next_f.cnt = 4'h0;
          case (lk_shifted)
            CMD_READ_CFG2: begin
              next_f.st     = LK_READ;
              next_f.rd_sel = 1'b0;
              next_f.sh_out = r.snap2;
            end
            CMD_READ_CFG3: begin
              next_f.st     = LK_READ;
              next_f.rd_sel = 1'b1;
              next_f.sh_out = r.snap3;
            end
            CMD_SET_BURST: begin
              next_f.st = LK_WRITE;
            end
            CMD_ENTER_QUAD, CMD_EXIT_QUAD, CMD_ENTER_4BYTE, CMD_EXIT_4BYTE: begin
              next_f.st    = LK_IDLE;
              next_ev.code = lk_shifted;
              next_ev.tog  = ~ev.tog;
            end
            default: begin
              next_f.st = LK_IDLE;
            end
          endcase
        end
      end
      LK_READ: begin
        next_f.cnt    = f.cnt + 4'h1;
        next_f.sh_out = lk_qpi ? {f.sh_out[3:0], 4'h0} : {f.sh_out[6:0], 1'b0};
        // Long reads repeat the same byte
        if (f.cnt == lk_last) begin
          next_f.cnt    = 4'h0;
          next_f.sh_out = f.rd_sel ? r.snap3 : r.snap2;
        end
      end
      LK_WRITE: begin
        next_f.sh_in = lk_shifted;
        next_f.cnt   = f.cnt + 4'h1;
        if (f.cnt == lk_last) begin
          next_f.st    = LK_IDLE;
          next_ev.code = CMD_SET_BURST;
          next_ev.data = lk_shifted;
          next_ev.tog  = ~ev.tog;
        end
      end
      LK_IDLE: begin
        next_f.st = LK_IDLE;
      end
      default: begin
        next_f.st = LK_IDLE;
      end
    endcase
  end

  // Frame state dies with select; sck gives no edge once it rises
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Event word outlives frames; code and data settle before the toggle is seen
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      ev <= '0;
    end else begin
      ev <= next_ev;
    end
  end

  // Read data on line two in serial mode, on all four in quad protocol
  always_comb begin
    link_doe  = 4'h0;
    link_dout = 4'h0;
    if (f.st == LK_READ) begin
      link_doe  = lk_qpi ? 4'hf : 4'h2;
      link_dout = lk_qpi ? f.sh_out[7:4] : {2'b00, f.sh_out[7], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Core side on mclk

  logic ev_pulse;
  logic load;

  always_comb begin
    next_r        = r;
    // Pin and cross-domain synchronisers
    next_r.cs_s1  = cs_n;
    next_r.cs_s2  = r.cs_s1;
    next_r.l4_s1  = link_din[3];
    next_r.l4_s2  = r.l4_s1;
    next_r.tog_s1 = ev.tog;
    next_r.tog_s2 = r.tog_s1;
    next_r.tog_s3 = r.tog_s2;
    ev_pulse      = r.tog_s2 ^ r.tog_s3;

    // Pin reset is honoured between frames, while quad-enable is clear, or while the protocol bit is clear; inside a frame the
    // width the frame began with counts too, as the pin sample lags the register by two cycles
    next_r.hw_req = r.cfg2[BIT_RST_EN]
                  & (r.cs_s2 | ~config_one_live[BIT_QUAD_EN]
                     | ~(r.cfg2[BIT_QPI] | r.snap2[BIT_QPI]))
                  & ~r.l4_s2;
    next_r.hw_req_d  = r.hw_req;
    next_r.load_pend = 1'b0;
    load = r.load_pend | sw_reset | (r.hw_req & ~r.hw_req_d);

    if (load) begin
      // Power-on, pin and software reset all reload from the stored copies
      next_r.cfg2              = config_two_stored;
      next_r.cfg2[BIT_CUR_ALN] = config_two_stored[BIT_BOOT_ALN];
      next_r.cfg3              = config_three_stored;
    end else begin
      if (reg_wr && !reg_wr_sel) begin
        // Boot length stays read-only here
        next_r.cfg2 = (reg_wr_data & CFG2_WR_MASK) | (r.cfg2 & ~CFG2_WR_MASK);
      end
      if (reg_wr && reg_wr_sel) begin
        next_r.cfg3 = reg_wr_data;
      end
      if (ev_pulse) begin
        // Quad commands move only the protocol bit; quad-enable lives elsewhere and is untouched
        case (ev.code)
          CMD_ENTER_QUAD:  next_r.cfg2[BIT_QPI]     = 1'b1;
          CMD_EXIT_QUAD:   next_r.cfg2[BIT_QPI]     = 1'b0;
          CMD_ENTER_4BYTE: next_r.cfg2[BIT_CUR_ALN] = 1'b1;
          CMD_EXIT_4BYTE:  next_r.cfg2[BIT_CUR_ALN] = 1'b0;
          CMD_SET_BURST:   next_r.cfg3              = ev.data;
          default:         next_r.cfg3              = next_r.cfg3;
        endcase
      end
      if (stored_alen_upd) begin
        next_r.cfg2[BIT_BOOT_ALN] = stored_alen_val;
        next_r.cfg2[BIT_CUR_ALN]  = stored_alen_val;
      end
    end
    next_r.cfg2[BIT_RSV] = 1'b0;

    // Snapshots for the link move only between frames
    if (r.cs_s2) begin
      next_r.snap2 = r.cfg2;
      next_r.snap3 = r.cfg3;
    end

    // Line usage table
    next_r.mode.quad_active     = r.cfg2[BIT_QPI] | config_one_live[BIT_QUAD_EN];
    next_r.mode.line_three_data = next_r.mode.quad_active;
    next_r.mode.line_four_data  = next_r.mode.quad_active;
    next_r.mode.single_ok       = ~r.cfg2[BIT_QPI];
    next_r.mode.dual_ok         = ~r.cfg2[BIT_QPI];
    next_r.mode.quad_ok         = next_r.mode.quad_active;

    // Wrap never touches register or security region reads
    next_r.wrap_active = array_read & ~r.cfg3[BIT_WRAP_DIS];
  end

  // Core register; a reload is queued to run right after reset release
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r           <= '0;
      r.cs_s1     <= 1'b1;
      r.cs_s2     <= 1'b1;
      r.l4_s1     <= 1'b1;
      r.l4_s2     <= 1'b1;
      r.cfg2      <= CFG2_RST;
      r.cfg3      <= CFG3_RST;
      r.load_pend <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from core flops
  assign config_two_live           = r.cfg2;
  assign config_three_live         = r.cfg3;
  assign drive_strength_sel        = r.cfg2[BIT_DRV_HI:BIT_DRV_LO];
  assign protection_scheme_sel     = r.cfg2[BIT_PROT];
  assign current_addr_len          = r.cfg2[BIT_CUR_ALN];
  assign quad_instruction_protocol = r.cfg2[BIT_QPI];
  assign mode                      = r.mode;
  assign line_four_reset_req       = r.hw_req;
  assign burst_wrap_active         = r.wrap_active;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the core domain

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_quad_enter: assert property (ev_pulse && !load && ev.code == CMD_ENTER_QUAD
    |=> config_two_live[BIT_QPI]) else $error("enter quad did not set protocol bit");

  a_quad_exit: assert property (ev_pulse && !load && ev.code == CMD_EXIT_QUAD
    |=> !config_two_live[BIT_QPI]) else $error("exit quad did not clear protocol bit");

  a_four_byte: assert property (ev_pulse && !load && !stored_alen_upd
    && (ev.code == CMD_ENTER_4BYTE || ev.code == CMD_EXIT_4BYTE)
    |=> current_addr_len == ($past(ev.code) == CMD_ENTER_4BYTE))
    else $error("four byte command gave wrong address length");

  a_rsv_zero: assert property (!config_two_live[BIT_RSV])
    else $error("reserved bit read as one");

  a_boot_ro: assert property (reg_wr && !reg_wr_sel && !load && !stored_alen_upd
    |=> $stable(config_two_live[BIT_BOOT_ALN])) else $error("boot length changed by write");

  a_alen_follow: assert property (stored_alen_upd && !load
    |=> current_addr_len == $past(stored_alen_val)
        && config_two_live[BIT_BOOT_ALN] == $past(stored_alen_val))
    else $error("current length did not follow stored update");

  a_reload: assert property (load
    |=> config_three_live == $past(config_three_stored)
        && config_two_live[BIT_RST_EN] == $past(config_two_stored[BIT_RST_EN]))
    else $error("reset did not reload live registers");

  a_pin_off: assert property (!config_two_live[BIT_RST_EN]
    |=> !line_four_reset_req) else $error("pin reset raised while disabled");

  a_pin_data: assert property (config_two_live[BIT_QPI] && config_one_live[BIT_QUAD_EN]
    && !r.cs_s2 |=> !line_four_reset_req) else $error("pin reset taken while line carries data");

  a_quad_force: assert property (config_two_live[BIT_QPI]
    |=> mode.quad_active && mode.quad_ok && !mode.single_ok)
    else $error("protocol bit did not force quad only");

  a_wrap_array: assert property (burst_wrap_active |-> $past(array_read))
    else $error("wrap active on non-array read");

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on field writes, reload and line usage

  // Register port writes land in the next cycle when nothing of higher priority moves
  a_wr_drive: assert property (reg_wr && !reg_wr_sel && !load
    |=> drive_strength_sel == $past(reg_wr_data[BIT_DRV_HI:BIT_DRV_LO]))
    else $error("drive strength write did not land");

  a_wr_protect: assert property (reg_wr && !reg_wr_sel && !load
    |=> protection_scheme_sel == $past(reg_wr_data[BIT_PROT]))
    else $error("protection select write did not land");

  a_cfg3_write: assert property (reg_wr && reg_wr_sel && !load && !ev_pulse
    |=> config_three_live == $past(reg_wr_data))
    else $error("config three write did not land");

  a_burst_set: assert property (ev_pulse && !load && ev.code == CMD_SET_BURST
    |=> config_three_live == $past(ev.data))
    else $error("set burst command did not load config three");

  a_boot_load: assert property (load
    |=> config_two_live[BIT_BOOT_ALN] == $past(config_two_stored[BIT_BOOT_ALN])
        && current_addr_len == $past(config_two_stored[BIT_BOOT_ALN]))
    else $error("reload gave wrong address length");

  a_reload_fields: assert property (load
    |=> drive_strength_sel == $past(config_two_stored[BIT_DRV_HI:BIT_DRV_LO])
        && protection_scheme_sel == $past(config_two_stored[BIT_PROT]))
    else $error("reload gave wrong drive or protection");

  // Pin reset: taken between frames, never inside a quad protocol frame with quad-enable set
  a_pin_take: assert property (config_two_live[BIT_RST_EN] && r.cs_s2 && !r.l4_s2
    |=> line_four_reset_req) else $error("pin reset missed while deselected");

  a_frame_width: assert property (!r.cs_s2 && r.snap2[BIT_QPI]
    && config_one_live[BIT_QUAD_EN] |=> !line_four_reset_req)
    else $error("pin reset taken inside a quad protocol frame");

  a_snap_frozen: assert property (!r.cs_s2 |=> $stable(r.snap2) && $stable(r.snap3))
    else $error("link snapshot moved inside a frame");

  // Line usage per protocol and quad-enable pairing
  a_sio_mode: assert property (!config_two_live[BIT_QPI] && !config_one_live[BIT_QUAD_EN]
    |=> !mode.quad_ok && !mode.line_three_data && mode.single_ok && mode.dual_ok)
    else $error("single line mode decoded wrongly");

  a_qio_mode: assert property (!config_two_live[BIT_QPI] && config_one_live[BIT_QUAD_EN]
    |=> mode.quad_ok && mode.line_four_data && mode.single_ok && mode.dual_ok)
    else $error("quad data mode decoded wrongly");

  a_qpi_no_dual: assert property (config_two_live[BIT_QPI]
    |=> !mode.dual_ok && mode.line_three_data && mode.line_four_data)
    else $error("quad protocol still allows dual reads");

  a_wrap_off: assert property (config_three_live[BIT_WRAP_DIS]
    |=> !burst_wrap_active) else $error("wrap active while disabled");

endmodule

// [rtl/vmcr_pkg.sv]
// Shared constants and types for the volatile mode configuration registers
package vmcr_pkg;

  // Serial command codes seen at the link
  localparam logic [7:0] CMD_ENTER_QUAD  = 8'h38;
  localparam logic [7:0] CMD_EXIT_QUAD   = 8'hf5;
  localparam logic [7:0] CMD_ENTER_4BYTE = 8'hb7;
  localparam logic [7:0] CMD_EXIT_4BYTE  = 8'he9;
  localparam logic [7:0] CMD_READ_CFG2   = 8'h15;
  localparam logic [7:0] CMD_READ_CFG3   = 8'h33;
  localparam logic [7:0] CMD_SET_BURST   = 8'h77;

  // Field positions in config_two_live
  localparam int unsigned BIT_RST_EN   = 7;
  localparam int unsigned BIT_DRV_HI   = 6;
  localparam int unsigned BIT_DRV_LO   = 5;
  localparam int unsigned BIT_RSV      = 4;
  localparam int unsigned BIT_QPI      = 3;
  localparam int unsigned BIT_PROT     = 2;
  localparam int unsigned BIT_BOOT_ALN = 1;
  localparam int unsigned BIT_CUR_ALN  = 0;

  // Field positions in the other configuration registers
  localparam int unsigned BIT_QUAD_EN  = 1;
  localparam int unsigned BIT_WRAP_DIS = 4;

  // Values held before the first reload, and host-writable bits
  localparam logic [7:0] CFG2_RST     = 8'h00;
  localparam logic [7:0] CFG3_RST     = 8'h00;
  localparam logic [7:0] CFG2_WR_MASK = 8'hed;

  // Last shift count of one byte on the link
  localparam logic [3:0] LAST_SINGLE = 4'h7;
  localparam logic [3:0] LAST_QUAD   = 4'h1;

  // Link frame phases
  typedef enum logic [1:0] {LK_CMD, LK_READ, LK_WRITE, LK_IDLE} vmcr_lk_state_t;

  // Decoded line usage and read widths
  typedef struct packed {
    logic quad_active;
    logic line_three_data;
    logic line_four_data;
    logic single_ok;
    logic dual_ok;
    logic quad_ok;
  } vmcr_mode_t;

  // Core state on mclk
  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       l4_s1;
    logic       l4_s2;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic       load_pend;
    logic       hw_req;
    logic       hw_req_d;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] snap2;
    logic [7:0] snap3;
    vmcr_mode_t mode;
    logic       wrap_active;
  } vmcr_core_t;

  // Per-frame state on the link clock
  typedef struct packed {
    vmcr_lk_state_t st;
    logic [3:0]     cnt;
    logic           rd_sel;
    logic [7:0]     sh_in;
    logic [7:0]     sh_out;
  } vmcr_frame_t;

  // Command event handed from the link to the core
  typedef struct packed {
    logic       tog;
    logic [7:0] code;
    logic [7:0] data;
  } vmcr_event_t;

endpackage

// [verification/vmcr_host.sv]
// Host-side serial controller model that issues command frames on the link
`timescale 1ns/100ps

////////////////////////////////////////////////////////////
module vmcr_host (
  output logic            sck,       // Link clock, still between frames
  output logic            cs_n,      // Chip select, active low
  output logic      [3:0] host_val,  // Levels the host puts on the data lines
  input  wire logic [3:0] link_dout, // Device data out
  input  wire logic       rst_pin_n, // Bench pulls line four low for a pin reset
  output logic      [7:0] rd_byte,   // Last byte read back
  output logic            rd_valid   // Short pulse when rd_byte is new
);
  logic [3:0] v;

  // Line four idles high, like the pull-up on a reset pin
  assign host_val = {v[3] & rst_pin_n, v[2:0]};

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    v = 4'hf;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
  end

  // One link clock period with the host lines set while the clock is low
  task automatic clk1(input logic [3:0] d);
    v = d;
    #7.5 sck = 1'b1;
    #7.5 sck = 1'b0;
  endtask

  // One whole frame: instruction, optional data byte, optional read byte
  task automatic frame(input logic [7:0] cmd, input logic q, input logic wr,
                       input logic [7:0] wd, input logic rd);
    logic [7:0] b;
    int         n;
    n = q ? 2 : 8;
    b = 8'h00;
    cs_n = 1'b0;
    #4.1;
    for (int i = 0; i < n; i++) clk1(q ? cmd[7-4*i -: 4] : {3'h7, cmd[7-i]});
    if (wr) begin
      for (int i = 0; i < n; i++) clk1(q ? wd[7-4*i -: 4] : {3'h7, wd[7-i]});
    end
    if (rd) begin
      // Lines one to three toggle so a stale level never passes for device data; line four keeps its level
      for (int i = 0; i < n; i++) begin
        v = v ^ 4'h7;
        #7.5 b = q ? {b[3:0], link_dout} : {b[6:0], link_dout[1]};
        sck = 1'b1;
        #7.5 sck = 1'b0;
      end
      rd_byte = b;
      rd_valid = 1'b1;
      #1 rd_valid = 1'b0;
    end
    // Lines back high before deselect so no pin reset is seen at the seam
    #7.5 v = 4'hf;
    #3 cs_n = 1'b1;
    #60;
  endtask
endmodule

// [verification/vmcr_regs_tb.sv]
// Self-checking bench for the volatile mode configuration registers
`timescale 1ns/100ps

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

////////////////////////////////////////////////////////////
module vmcr_regs_tb;
  import vmcr_pkg::*;
  logic       mclk, nrst, sck, cs_n, rst_pin_n, rd_valid, sw_reset;
  logic       stored_alen_upd, stored_alen_val, reg_wr, reg_wr_sel, array_read;
  logic       line_four_reset_req, burst_wrap_active, protection_scheme_sel;
  logic       current_addr_len, quad_instruction_protocol;
  logic [1:0] drive_strength_sel;
  logic [3:0] link_din, link_dout, link_doe, host_val;
  logic [7:0] config_one_live, config_two_stored, config_three_stored, reg_wr_data;
  logic [7:0] config_two_live, config_three_live, rd_byte, exp2, exp3, rnd, e;
  vmcr_mode_t mode;
  logic [7:0] expq[$];
  int         err_total, total_checks, cycles;

  // Each line shows whichever side drives it
  assign link_din = (link_doe & link_dout) | (~link_doe & host_val);

  vmcr_regs uut (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .link_din(link_din),
    .link_dout(link_dout), .link_doe(link_doe), .config_one_live(config_one_live),
    .config_two_stored(config_two_stored), .config_three_stored(config_three_stored),
    .sw_reset(sw_reset), .stored_alen_upd(stored_alen_upd),
    .stored_alen_val(stored_alen_val), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .array_read(array_read), .config_two_live(config_two_live),
    .config_three_live(config_three_live), .drive_strength_sel(drive_strength_sel),
    .protection_scheme_sel(protection_scheme_sel), .current_addr_len(current_addr_len),
    .quad_instruction_protocol(quad_instruction_protocol), .mode(mode),
    .line_four_reset_req(line_four_reset_req), .burst_wrap_active(burst_wrap_active));

  vmcr_host host (.sck(sck), .cs_n(cs_n), .host_val(host_val), .link_dout(link_dout),
    .rst_pin_n(rst_pin_n), .rd_byte(rd_byte), .rd_valid(rd_valid));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Read-back watcher: every byte from the host is matched to the oldest note
  always @(posedge rd_valid) begin
    e = expq.pop_front();
    `CHK("link read", e, rd_byte)
  end

  // Hang guard, far above the under one thousand cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Frames follow the protocol width the device currently expects
  task automatic cmd(input logic [7:0] c, input logic wr, input logic [7:0] d,
                     input logic rd);
    host.frame(c, exp2[3], wr, d, rd);
    cyc(6);
  endtask

  task automatic rd2();
    expq.push_back(exp2);
    cmd(CMD_READ_CFG2, 1'b0, 8'h00, 1'b1);
  endtask

  task automatic rd3();
    expq.push_back(exp3);
    cmd(CMD_READ_CFG3, 1'b0, 8'h00, 1'b1);
  endtask

  task automatic chk_regs();
    `CHK("config two", exp2, config_two_live)
    `CHK("config three", exp3, config_three_live)
  endtask

  // Write port pulse; masked bits of config two keep their old value
  task automatic wreg(input logic s, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_wr_sel = s;
    reg_wr_data = d;
    cyc(1);
    reg_wr = 1'b0;
    if (s) exp3 = d;
    else exp2 = (exp2 & ~CFG2_WR_MASK) | (d & CFG2_WR_MASK);
    cyc(3);
  endtask

  task automatic pulse_sw();
    sw_reset = 1'b1;
    cyc(1);
    sw_reset = 1'b0;
    cyc(4);
  endtask

  initial begin
    {nrst, sw_reset, stored_alen_upd, stored_alen_val, reg_wr, reg_wr_sel} = 6'h00;
    {reg_wr_data, array_read, rst_pin_n, rnd} = {8'h00, 1'b0, 1'b1, 8'h33};
    config_one_live = 8'h02;
    config_two_stored = 8'h96;
    config_three_stored = 8'h70;
    cyc(16);
    nrst = 1'b1;
    cyc(4);
    exp2 = 8'h87;
    exp3 = 8'h70;
    chk_regs();
    rd2();
    rd3();
    cmd(CMD_ENTER_QUAD, 1'b0, 8'h00, 1'b0);
    exp2[3] = 1'b1;
    `CHK("protocol", 1'b1, quad_instruction_protocol)
    rd2();
    cmd(CMD_EXIT_QUAD, 1'b0, 8'h00, 1'b0);
    exp2[3] = 1'b0;
    chk_regs();
    cmd(CMD_EXIT_4BYTE, 1'b0, 8'h00, 1'b0);
    exp2[0] = 1'b0;
    `CHK("addr len", 1'b0, current_addr_len)
    cmd(CMD_ENTER_4BYTE, 1'b0, 8'h00, 1'b0);
    exp2[0] = 1'b1;
    chk_regs();
    rnd = lfsr_next(rnd);
    cmd(CMD_SET_BURST, 1'b1, rnd & 8'hef, 1'b0);
    exp3 = rnd & 8'hef;
    chk_regs();
    rd3();
    array_read = 1'b1;
    cyc(3);
    `CHK("wrap on", 1'b1, burst_wrap_active)
    array_read = 1'b0;
    cyc(3);
    `CHK("wrap off", 1'b0, burst_wrap_active)
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      wreg(i[0], rnd);
      chk_regs();
      `CHK("drive", exp2[6:5], drive_strength_sel)
      `CHK("protect", exp2[2], protection_scheme_sel)
    end
    rd2();
    // Every pairing of protocol bit and quad-enable bit
    for (int i = 0; i < 4; i++) begin
      wreg(1'b0, (exp2 & 8'hf7) | {4'h0, i[1], 3'h0});
      config_one_live = {6'h00, i[0], 1'b0};
      cyc(3);
      `CHK("quad active", i[1] | i[0], mode.quad_active)
      `CHK("line three", i[1] | i[0], mode.line_three_data)
      `CHK("line four", i[1] | i[0], mode.line_four_data)
      `CHK("single", !i[1], mode.single_ok)
      `CHK("dual", !i[1], mode.dual_ok)
      `CHK("quad read", i[1] | i[0], mode.quad_ok)
    end
    stored_alen_val = ~exp2[1];
    stored_alen_upd = 1'b1;
    cyc(1);
    stored_alen_upd = 1'b0;
    exp2[1:0] = {2{stored_alen_val}};
    cyc(3);
    chk_regs();
    wreg(1'b0, exp2 | 8'h80);
    rst_pin_n = 1'b0;
    cyc(8);
    `CHK("pin reset", 1'b1, line_four_reset_req)
    rst_pin_n = 1'b1;
    cyc(6);
    exp2 = 8'h87;
    exp3 = 8'h70;
    chk_regs();
    wreg(1'b0, exp2 & 8'h7f);
    rst_pin_n = 1'b0;
    cyc(8);
    `CHK("no pin reset", 1'b0, line_four_reset_req)
    chk_regs();
    rst_pin_n = 1'b1;
    wreg(1'b1, 8'h05);
    pulse_sw();
    exp2 = 8'h87;
    exp3 = 8'h70;
    chk_regs();
    rd3();
    test_done();
  end
endmodule
